// File: common/dmr_pkg.sv
// Shared constants for the second and third mode registers of the memory.
// Assumes a 4-bit command code formed as {cs_n, ras_n, cas_n, we_n}.
package dmr_pkg;
  localparam int          MR_W        = 18;
  localparam logic [2:0]  BA_MR2      = 3'h2;
  localparam logic [2:0]  BA_MR3      = 3'h3;
  localparam logic [3:0]  CMD_MRS     = 4'h0;
  localparam int          CWL_LSB     = 3;
  localparam int          CWL_W       = 3;
  localparam logic [3:0]  CWL_BASE    = 4'h5;
  localparam int          ASR_BIT     = 6;
  localparam int          SRT_BIT     = 7;
  localparam int          RTT_WR_LSB  = 9;
  localparam int          MPR_EN_BIT  = 2;
  localparam int          MPR_SEL_LSB = 0;
  localparam logic [1:0]  MPR_PREDEF  = 2'h0;
  localparam logic [4:0]  BURST_CYC   = 5'h04;
  localparam logic [7:0]  PATTERN     = 8'hAA;
  localparam logic [17:0] MR_RST      = 18'h0_0000;
  localparam logic [1:0]  TERM_OFF    = 2'h0;
  localparam logic [1:0]  TERM_NOM    = 2'h1;
  localparam logic [1:0]  TERM_WR     = 2'h2;

  typedef enum logic [2:0] {
    ST_NOM  = 3'h1,
    ST_WAIT = 3'h2,
    ST_WRT  = 3'h4
  } dmr_term_e;
endpackage : dmr_pkg

// File: common/dmr_mr_if.sv
// Handshake carrying captured mode register words from the link domain.
// Assumes the link end holds the words stable while req and ack differ.
`timescale 1ns/10ps
`default_nettype none
interface dmr_mr_if;
  logic [17:0] mr2;
  logic [17:0] mr3;
  logic        req_tgl;
  logic        ack_tgl;
  modport link (output mr2, output mr3, output req_tgl, input ack_tgl);
  modport core (input mr2, input mr3, input req_tgl, output ack_tgl);
endinterface : dmr_mr_if
`default_nettype wire

// File: src/dmr_link_capture.sv
// Link-domain decoder that captures mode register set commands.
// Assumes command pins are synchronous to i_cmd_clk and that i_cmd_clk runs
// while reset is applied, so the local reset copy can settle.
`timescale 1ns/10ps
`default_nettype none
module dmr_link_capture (
  input  wire logic        i_cmd_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_ba,
  input  wire logic [14:0] i_addr,
  dmr_mr_if.link           xf
);
  logic [1:0]  rs_q, rs_d;
  logic [1:0]  as_q, as_d;
  logic [17:0] s2_q, s2_d, s3_q, s3_d, o2_d, o3_d;
  logic        pend_q, pend_d, req_d, mode_register_set_cmd, hit2, hit3, send;

  always_comb begin
    rs_d   = {rs_q[0], i_rst};
    as_d   = {as_q[0], xf.ack_tgl};
    mode_register_set_cmd    = {i_cs_n, i_ras_n, i_cas_n, i_we_n} == dmr_pkg::CMD_MRS;
    hit2   = mode_register_set_cmd && (i_ba == dmr_pkg::BA_MR2);
    hit3   = mode_register_set_cmd && (i_ba == dmr_pkg::BA_MR3);
    s2_d   = hit2 ? {i_ba, i_addr} : s2_q;
    s3_d   = hit3 ? {i_ba, i_addr} : s3_q;
    // A new command during a transfer is kept pending and resent later.
    send   = (pend_q | hit2 | hit3) && (xf.req_tgl == as_q[1]);
    pend_d = (pend_q | hit2 | hit3) & ~send;
    o2_d   = send ? s2_d : xf.mr2;
    o3_d   = send ? s3_d : xf.mr3;
    req_d  = xf.req_tgl ^ send;
  end

  always_ff @(posedge i_cmd_clk) begin
    rs_q <= rs_d;
    if (rs_q[1]) begin
      as_q       <= 2'h0;
      s2_q       <= dmr_pkg::MR_RST;
      s3_q       <= dmr_pkg::MR_RST;
      pend_q     <= 1'b0;
      xf.mr2     <= dmr_pkg::MR_RST;
      xf.mr3     <= dmr_pkg::MR_RST;
      xf.req_tgl <= 1'b0;
    end else begin
      as_q       <= as_d;
      s2_q       <= s2_d;
      s3_q       <= s3_d;
      pend_q     <= pend_d;
      xf.mr2     <= o2_d;
      xf.mr3     <= o3_d;
      xf.req_tgl <= req_d;
    end
  end
endmodule : dmr_link_capture
`default_nettype wire

// File: src/dmr_mode_regs.sv
// Second and third mode registers with write latency, self refresh rate,
// write termination switching and calibration pattern read redirection.
// Assumes write and read releases come from command logic on i_ref_clk and
// that mode register words arrive from the link clock domain.
//
// Functional notes
// - Register contents persist until next register write
// - Register rewrite leaves array contents untouched
// - Bits 5:3 give write CAS latency
// - Total write latency is CAS plus additive
// - Bit 6 enables automatic self refresh rate
// - Automatic mode doubles rate when case hot
// - Bit 7 forces double self refresh rate
// - Bits 10:9 nonzero enable write termination
// - Write termination replaces nominal during burst
// - Write termination only in writes, independent
// - No write termination during write leveling
// - Bit 2 clear sends reads to array
// - Bit 2 set returns pattern on reads
// - Pattern returned on every read while selected with selector 00
// - Pattern alternates from zero, position0 LSB
// - Bank bits 010 and 011 select register
`timescale 1ns/10ps
`default_nettype none
module dmr_mode_regs (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cmd_clk,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_ba,
  input  wire logic [14:0] i_addr,
  input  wire logic [3:0]  i_additive_latency,
  input  wire logic        i_write_release,
  input  wire logic        i_read_release,
  input  wire logic        i_nominal_enable,
  input  wire logic        i_write_leveling,
  input  wire logic        i_temp_above_limit,
  output logic      [3:0]  o_write_cas_latency,
  output logic      [4:0]  o_total_write_latency,
  output logic             o_write_data_capture,
  output logic      [1:0]  o_die_term_mode,
  output logic      [1:0]  o_write_term_value,
  output logic             o_self_refresh_double,
  output logic             o_pattern_select,
  output logic             o_read_from_array,
  output logic             o_pattern_valid,
  output logic      [7:0]  o_pattern_data
);
  // Words captured at the link cross here by a toggle handshake.
  dmr_mr_if xf ();

  dmr_link_capture u_link (
    .i_cmd_clk (i_cmd_clk),
    .i_rst     (i_rst),
    .i_cs_n    (i_cs_n),
    .i_ras_n   (i_ras_n),
    .i_cas_n   (i_cas_n),
    .i_we_n    (i_we_n),
    .i_ba      (i_ba),
    .i_addr    (i_addr),
    .xf        (xf.link)
  );

  // Bit 0 carries the request toggle, bit 1 the temperature sensor level.
  logic [1:0]  sa_q, sa_d;
  logic [1:0]  sb_q, sb_d;
  logic        ack_d;
  logic        rx_evt;
  logic        temp_hot;
  logic [17:0] mr2_q, mr2_d;
  logic [17:0] mr3_q, mr3_d;

  always_comb begin
    sa_d     = {i_temp_above_limit, xf.req_tgl};
    sb_d     = sa_q;
    temp_hot = sb_q[1];
    rx_evt   = sb_q[0] ^ xf.ack_tgl;
    ack_d    = sb_q[0];
    mr2_d    = rx_evt ? xf.mr2 : mr2_q;
    mr3_d    = rx_evt ? xf.mr3 : mr3_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sa_q       <= 2'h0;
      sb_q       <= 2'h0;
      xf.ack_tgl <= 1'b0;
      mr2_q      <= dmr_pkg::MR_RST;
      mr3_q      <= dmr_pkg::MR_RST;
    end else begin
      sa_q       <= sa_d;
      sb_q       <= sb_d;
      xf.ack_tgl <= ack_d;
      mr2_q      <= mr2_d;
      mr3_q      <= mr3_d;
    end
  end

  logic [3:0] cwl_d;
  logic [4:0] wl_d;
  logic       srd_d;
  logic       psel_d;
  logic [1:0] wterm_d;

  always_comb begin
    cwl_d   = 4'(mr2_q[dmr_pkg::CWL_LSB +: dmr_pkg::CWL_W])
            + dmr_pkg::CWL_BASE;
    wl_d    = {1'b0, cwl_d} + {1'b0, i_additive_latency};
    // Fixed mode wins outright; automatic mode follows the sensor.
    srd_d   = mr2_q[dmr_pkg::SRT_BIT]
            | (mr2_q[dmr_pkg::ASR_BIT] & temp_hot);
    psel_d  = mr3_q[dmr_pkg::MPR_EN_BIT];
    wterm_d = mr2_q[dmr_pkg::RTT_WR_LSB +: 2];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_write_cas_latency   <= dmr_pkg::CWL_BASE;
      o_total_write_latency <= {1'b0, dmr_pkg::CWL_BASE};
      o_self_refresh_double <= 1'b0;
      o_pattern_select      <= 1'b0;
      o_write_term_value    <= 2'h0;
    end else begin
      o_write_cas_latency   <= cwl_d;
      o_total_write_latency <= wl_d;
      o_self_refresh_double <= srd_d;
      o_pattern_select      <= psel_d;
      o_write_term_value    <= wterm_d;
    end
  end

  // Write timing and termination switching. A release that arrives while
  // a write is still being timed is ignored; the controller spaces writes.
  dmr_pkg::dmr_term_e st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic       cap_d;
  logic       dyn_en;
  logic [1:0] term_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    cap_d  = 1'b0;
    dyn_en = mr2_q[dmr_pkg::RTT_WR_LSB +: 2] != 2'h0;
    case (st_q)
      dmr_pkg::ST_NOM: begin
        if (i_write_release) begin
          st_d  = dmr_pkg::ST_WAIT;
          cnt_d = o_total_write_latency - 5'h01;
        end
      end
      dmr_pkg::ST_WAIT: begin
        if (cnt_q == 5'h01) begin
          st_d  = dmr_pkg::ST_WRT;
          cnt_d = dmr_pkg::BURST_CYC - 5'h01;
          cap_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      dmr_pkg::ST_WRT: begin
        if (cnt_q == 5'h00) begin
          st_d = dmr_pkg::ST_NOM;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      default: begin
        st_d  = dmr_pkg::ST_NOM;
        cnt_d = 5'h00;
      end
    endcase
    if (st_d == dmr_pkg::ST_WRT && dyn_en && !i_write_leveling) begin
      term_d = dmr_pkg::TERM_WR;
    end else if (i_nominal_enable) begin
      term_d = dmr_pkg::TERM_NOM;
    end else begin
      term_d = dmr_pkg::TERM_OFF;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q                 <= dmr_pkg::ST_NOM;
      cnt_q                <= 5'h00;
      o_write_data_capture <= 1'b0;
      o_die_term_mode      <= dmr_pkg::TERM_OFF;
    end else begin
      st_q                 <= st_d;
      cnt_q                <= cnt_d;
      o_write_data_capture <= cap_d;
      o_die_term_mode      <= term_d;
    end
  end

  // Read redirection. Reserved selector codes return all zeros.
  logic       rd_arr_d;
  logic       pv_d;
  logic [7:0] pdata_d;

  always_comb begin
    rd_arr_d = i_read_release & ~mr3_q[dmr_pkg::MPR_EN_BIT];
    pv_d     = i_read_release & mr3_q[dmr_pkg::MPR_EN_BIT];
    if (pv_d && mr3_q[dmr_pkg::MPR_SEL_LSB +: 2] == dmr_pkg::MPR_PREDEF) begin
      pdata_d = dmr_pkg::PATTERN;
    end else begin
      pdata_d = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_read_from_array <= 1'b0;
      o_pattern_valid   <= 1'b0;
      o_pattern_data    <= 8'h00;
    end else begin
      o_read_from_array <= rd_arr_d;
      o_pattern_valid   <= pv_d;
      o_pattern_data    <= pdata_d;
    end
  end

  // Cycles since a write release was taken, used only by the checks. It is
  // six bits wide so the longest total write latency cannot wrap it.
  logic [5:0] hc_q, hc_d;

  always_comb begin
    if (st_q == dmr_pkg::ST_NOM && i_write_release) begin
      hc_d = 6'h01;
    end else if (st_q == dmr_pkg::ST_NOM) begin
      hc_d = 6'h00;
    end else begin
      hc_d = hc_q + 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hc_q <= 6'h00;
    end else begin
      hc_q <= hc_d;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  mr_hold_a : assert property (
    !rx_evt |=> $stable(mr2_q) && $stable(mr3_q))
    else $error("mode register changed without a transfer");

  cwl_map_a : assert property (
    rx_evt |-> ##2 (o_write_cas_latency ==
      4'($past(xf.mr2[dmr_pkg::CWL_LSB +: dmr_pkg::CWL_W], 2))
      + dmr_pkg::CWL_BASE))
    else $error("write CAS latency does not match field");

  wr_latency_a : assert property (
    o_write_data_capture |-> {1'b0, o_total_write_latency} == hc_q)
    else $error("write data captured at wrong latency");

  sr_normal_a : assert property (
    (!mr2_q[dmr_pkg::ASR_BIT] && !mr2_q[dmr_pkg::SRT_BIT])
      |=> !o_self_refresh_double)
    else $error("double self refresh without enable");

  sr_auto_a : assert property (
    (mr2_q[dmr_pkg::ASR_BIT] && temp_hot) |=> o_self_refresh_double)
    else $error("automatic mode missed hot case");

  sr_fixed_a : assert property (
    mr2_q[dmr_pkg::SRT_BIT] |=> o_self_refresh_double)
    else $error("fixed double refresh not applied");

  term_burst_a : assert property (
    o_write_data_capture |-> (st_q == dmr_pkg::ST_WRT) [*4]
      ##1 (st_q == dmr_pkg::ST_NOM))
    else $error("write burst window has wrong length");

  term_only_wr_a : assert property (
    o_die_term_mode == dmr_pkg::TERM_WR |-> st_q == dmr_pkg::ST_WRT)
    else $error("write termination outside a write");

  level_no_dyn_a : assert property (
    i_write_leveling |=> o_die_term_mode != dmr_pkg::TERM_WR)
    else $error("write termination during leveling");

  array_read_a : assert property (
    (i_read_release && !mr3_q[dmr_pkg::MPR_EN_BIT])
      |=> o_read_from_array && !o_pattern_valid)
    else $error("read not sent to array");

  pattern_rd_a : assert property (
    (i_read_release && mr3_q[dmr_pkg::MPR_EN_BIT]
      && mr3_q[dmr_pkg::MPR_SEL_LSB +: 2] == dmr_pkg::MPR_PREDEF)
      |=> o_pattern_valid && o_pattern_data == dmr_pkg::PATTERN
      && !o_read_from_array)
    else $error("calibration pattern not returned");
endmodule : dmr_mode_regs
`default_nettype wire

// File: verif/dmr_ctrl_model.sv
// Memory controller model that issues mode register set commands.
// Assumes callers only send words with banks idle and reserved bits zero.
`timescale 1ns/10ps
`default_nettype none
module dmr_ctrl_model (
  input  wire logic        i_cmd_clk,
  output var  logic        o_cs_n,
  output var  logic        o_ras_n,
  output var  logic        o_cas_n,
  output var  logic        o_we_n,
  output var  logic [2:0]  o_ba,
  output var  logic [14:0] o_addr
);
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    {o_ba, o_addr} = 18'h0_0000;
  end

  // Deselected lines carry the inverse word so no stale value is read.
  task automatic send_mrs(input logic [17:0] word);
    // Pins move on the falling edge, half a period clear of the sampling edge.
    @(negedge i_cmd_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = dmr_pkg::CMD_MRS;
    {o_ba, o_addr} = word;
    @(negedge i_cmd_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    {o_ba, o_addr} = ~word;
    repeat (8) @(posedge i_cmd_clk);
  endtask : send_mrs
endmodule : dmr_ctrl_model
`default_nettype wire

// File: verif/dram_mode_regs_calib_pattern_bench.sv
// Self-checking bench for the second and third mode registers.
// Assumes the controller model drives command pins on the link clock.
`timescale 1ns/10ps
`default_nettype none
module dram_mode_regs_calib_pattern_bench;
  typedef struct packed {
    logic [2:0] f;
    logic [3:0] al;
    logic [1:0] rtt;
    logic       auto_temp_self_refresh;
    logic       fixed_double_self_refresh;
    logic       hot;
    logic       nom;
    logic [3:0] e_cwl;
    logic [4:0] e_wl;
    logic       e_sr;
  } dmr_row_s;
  logic        ref_clk = 1'h0;
  logic        cmd_clk = 1'h0;
  logic        rst;
  logic [3:0]  al = 4'h0;
  logic        wr_rel = 1'h0;
  logic        rd_rel = 1'h0;
  logic        nom = 1'h0;
  logic        lvl = 1'h0;
  logic        hot = 1'h0;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [14:0] addr;
  logic [3:0]  write_cas_latency;
  logic [4:0]  wl;
  logic        cap, srd, psel, rarr, pval;
  logic [1:0]  term, tval;
  logic [7:0]  pdat;
  int          err_total = 0;
  int          checks_done = 0;
  dmr_row_s    rows [8];
  dmr_row_s    r;

  always #4 ref_clk = ~ref_clk;
  always #62.5 cmd_clk = ~cmd_clk;

  dmr_ctrl_model ctl (.i_cmd_clk(cmd_clk), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));

  dmr_mode_regs uut (.i_ref_clk(ref_clk), .i_rst(rst), .i_cmd_clk(cmd_clk),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_ba(ba), .i_addr(addr), .i_additive_latency(al),
    .i_write_release(wr_rel), .i_read_release(rd_rel),
    .i_nominal_enable(nom), .i_write_leveling(lvl),
    .i_temp_above_limit(hot), .o_write_cas_latency(write_cas_latency),
    .o_total_write_latency(wl), .o_write_data_capture(cap),
    .o_die_term_mode(term), .o_write_term_value(tval),
    .o_self_refresh_double(srd), .o_pattern_select(psel),
    .o_read_from_array(rarr), .o_pattern_valid(pval),
    .o_pattern_data(pdat));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h want %h", $time, what, seen,
               exp);
    end
  endtask : check

  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // The link copy of reset needs several link edges, hence the long hold.
  task automatic do_reset();
    rst = 1'h1;
    repeat (70) @(negedge ref_clk);
    check(write_cas_latency, 4'h5, "reset cas latency");
    check(psel, 1'h0, "reset pattern select");
    rst = 1'h0;
    repeat (4) @(posedge cmd_clk);
    @(negedge ref_clk);
  endtask : do_reset

  // A second release one cycle later must be ignored.
  task automatic do_write(input logic [4:0] lat, input logic [1:0] tm,
                          input logic [1:0] aft);
    int n;
    n = 0;
    @(negedge ref_clk);
    wr_rel = 1'h1;
    do begin
      @(negedge ref_clk);
      n++;
      wr_rel = (n == 1);
    end while (cap !== 1'h1 && n < 40);
    check(16'(n), lat, "write latency");
    if (n == 40) give_verdict();
    check(term, tm, "termination in burst");
    for (int k = 1; k <= 4; k++) begin
      @(negedge ref_clk);
      check(cap, 1'h0, "extra capture");
    end
    check(term, aft, "termination after burst");
  endtask : do_write

  task automatic do_read(input logic arr, input logic [7:0] d,
                         input int cnt);
    @(negedge ref_clk);
    rd_rel = 1'h1;
    for (int k = 1; k <= cnt; k++) begin
      @(negedge ref_clk);
      rd_rel = (k < cnt);
      check(rarr, arr, "array read");
      check(pval, !arr, "pattern read");
      if (!arr) check(pdat, d, "pattern data");
    end
  endtask : do_read

  initial begin
    rows = '{
      '{3'h0, 4'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'h5, 5'h05, 1'h0},
      '{3'h1, 4'h1, 2'h1, 1'h1, 1'h0, 1'h1, 1'h0, 4'h6, 5'h07, 1'h1},
      '{3'h2, 4'h2, 2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 4'h7, 5'h09, 1'h0},
      '{3'h3, 4'h3, 2'h3, 1'h0, 1'h1, 1'h0, 1'h0, 4'h8, 5'h0b, 1'h1},
      '{3'h4, 4'h0, 2'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'h9, 5'h09, 1'h1},
      '{3'h5, 4'h4, 2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 4'ha, 5'h0e, 1'h0},
      '{3'h6, 4'h5, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1, 4'hb, 5'h10, 1'h0},
      '{3'h7, 4'h7, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 4'hc, 5'h13, 1'h0}};
    do_reset();
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      al = r.al;
      // Hot rows always enable one extended self refresh option, and the
      // case never leaves the range that self refresh alone can cover.
      hot = r.hot;
      nom = r.nom;
      ctl.send_mrs({dmr_pkg::BA_MR2, 4'h0, r.rtt, 1'h0, r.fixed_double_self_refresh, r.auto_temp_self_refresh, r.f,
                    3'h0});
      @(negedge ref_clk);
      check(write_cas_latency, r.e_cwl, "cas latency");
      check(wl, r.e_wl, "total latency");
      check(tval, r.rtt, "write term value");
      check(srd, r.e_sr, "double refresh");
      do_write(r.e_wl, (r.rtt != 2'h0) ? dmr_pkg::TERM_WR :
               (r.nom ? dmr_pkg::TERM_NOM : dmr_pkg::TERM_OFF),
               r.nom ? dmr_pkg::TERM_NOM : dmr_pkg::TERM_OFF);
    end
    lvl = 1'h1;
    nom = 1'h1;
    do_write(5'h13, dmr_pkg::TERM_NOM, dmr_pkg::TERM_NOM);
    lvl = 1'h0;
    ctl.send_mrs({3'h1, 15'h0000});
    @(negedge ref_clk);
    check(write_cas_latency, 4'hc, "other bank code");
    ctl.send_mrs({dmr_pkg::BA_MR3, 12'h000, 1'h0, 2'h1});
    do_read(1'h1, 8'h00, 2);
    ctl.send_mrs({dmr_pkg::BA_MR3, 12'h000, 1'h1, 2'h0});
    @(negedge ref_clk);
    check(psel, 1'h1, "pattern select");
    do_read(1'h0, 8'haa, 3);
    check(write_cas_latency, 4'hc, "second register kept");
    ctl.send_mrs({dmr_pkg::BA_MR3, 12'h000, 1'h1, 2'h1});
    do_read(1'h0, 8'h00, 1);
    do_reset();
    give_verdict();
  end
endmodule : dram_mode_regs_calib_pattern_bench
`default_nettype wire
